// ### rtl/presettable_binary_counter4.v
// top of the presettable binary counter with its ahb-lite register slave
// assumes one clock, synchronous active-high rst_i and synchronous pins;
// the single slave's hreadyout serves as the bus's hready
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`include "presettable_binary_counter4_regs.vh"

module presettable_binary_counter4 #(
  parameter WIDTH       = 4,
  parameter ASYNC_CLEAR = 1,
  parameter WRAP_WIDTH  = 16
) (
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // counter pins
  input  wire             async_clear_n_i,
  input  wire             sync_clear_n_i,
  input  wire             load_n_i,
  input  wire             enable_parallel_i,
  input  wire             enable_trickle_i,
  input  wire [WIDTH-1:0] preset_value_i,
  output wire [WIDTH-1:0] count_value_o,
  output reg              terminal_flag_o,
  // ahb-lite slave
  input  wire             hsel_i,
  input  wire [31:0]      haddr_i,
  input  wire [1:0]       htrans_i,
  input  wire             hwrite_i,
  input  wire [2:0]       hsize_i,
  input  wire [31:0]      hwdata_i,
  input  wire             hready_i,
  output reg  [31:0]      hrdata_o,
  output reg              hreadyout_o,
  output reg              hresp_o
);

  // -------------------------------------------------------------------
  // bus address phase capture
  // -------------------------------------------------------------------
  reg        wr_pending;
  reg [7:0]  wr_addr;
  wire       addr_phase;
  wire       take_write;
  wire       take_read;

  assign addr_phase = hsel_i & htrans_i[`PBC_HTRANS_ACTIVE] & hready_i;
  assign take_write = addr_phase & hwrite_i;
  assign take_read  = addr_phase & ~hwrite_i;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
    end else begin
      wr_pending <= take_write;
      if (take_write) begin
        wr_addr <= haddr_i[7:0];
      end
    end
  end

  // data phase of a write
  wire wr_ctrl;
  wire wr_preset;
  wire wr_wraps;
  wire wr_cmd;

  assign wr_ctrl   = wr_pending & (wr_addr == `PBC_CTRL_OFS);
  assign wr_preset = wr_pending & (wr_addr == `PBC_PRESET_OFS);
  assign wr_wraps  = wr_pending & (wr_addr == `PBC_WRAPS_OFS);
  assign wr_cmd    = wr_pending & (wr_addr == `PBC_CMD_OFS);

  // -------------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------------
  reg             count_gate;
  reg [WIDTH-1:0] sw_preset;
  reg             sw_load;
  reg             sw_clear;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_gate <= `PBC_CTRL_RST;
      sw_preset  <= `PBC_PRESET_RST;
    end else begin
      if (wr_ctrl) begin
        count_gate <= hwdata_i[`PBC_CTRL_GATE_BIT];
      end
      if (wr_preset) begin
        sw_preset <= hwdata_i[WIDTH-1:0];
      end
    end
  end

  // commands become one-cycle strobes the edge after the data phase
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      sw_load  <= 1'b0;
      sw_clear <= 1'b0;
    end else begin
      sw_load  <= wr_cmd & hwdata_i[`PBC_CMD_LOAD_BIT];
      sw_clear <= wr_cmd & hwdata_i[`PBC_CMD_CLEAR_BIT];
    end
  end

  // -------------------------------------------------------------------
  // counter controls
  // -------------------------------------------------------------------
  wire             pin_sync_clear;
  wire             core_clear;
  wire             core_load;
  wire [WIDTH-1:0] core_preset;
  wire             core_enable_p;
  wire [1:0]       last_action;
  wire             wrap;

  // the synchronous clear pin only acts in the synchronous variant
  assign pin_sync_clear = (ASYNC_CLEAR == 0) ? ~sync_clear_n_i : 1'b0;
  assign core_clear     = rst_i | sw_clear | pin_sync_clear;
  assign core_load      = ~load_n_i | sw_load;
  // a pin load wins over a software load in the same cycle
  assign core_preset    = load_n_i ? sw_preset : preset_value_i;
  // gate acts on the parallel enable so the trickle chain is untouched
  assign core_enable_p  = enable_parallel_i & count_gate;

  count_stage4 #(
    .WIDTH       (WIDTH),
    .ASYNC_CLEAR (ASYNC_CLEAR)
  ) u_stage (
    .sys_clk_i         (sys_clk_i),
    .async_clear_n_i   ((ASYNC_CLEAR != 0) ? async_clear_n_i : 1'b1),
    .sync_clear_i      (core_clear),
    .load_i            (core_load),
    .enable_parallel_i (core_enable_p),
    .enable_trickle_i  (enable_trickle_i),
    .preset_value_i    (core_preset),
    .count_value_o     (count_value_o),
    .last_action_o     (last_action),
    .wrap_o            (wrap)
  );

  // decoded from the stage flops and the trickle enable; cascaded parts
  // should use it as an enable, never as a clock or reset
  always @* begin
    terminal_flag_o = enable_trickle_i & (&count_value_o);
  end

  // -------------------------------------------------------------------
  // wrap counter: counting edges that roll fifteen over to zero
  // -------------------------------------------------------------------
  reg [WRAP_WIDTH-1:0] wraps;
  reg [WRAP_WIDTH-1:0] next_wraps;

  // a wrap in the clearing cycle is kept: the clear goes first
  always @* begin
    next_wraps = wraps;
    if (wr_wraps) begin
      next_wraps = {WRAP_WIDTH{1'b0}};
    end
    if (wrap) begin
      next_wraps = next_wraps + {{(WRAP_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      wraps <= `PBC_WRAPS_RST;
    end else begin
      wraps <= next_wraps;
    end
  end

  // -------------------------------------------------------------------
  // read mux, sampled at the address phase edge
  // -------------------------------------------------------------------
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr_i[7:0])
      `PBC_CTRL_OFS: begin
        next_rdata[`PBC_CTRL_GATE_BIT] = count_gate;
      end
      `PBC_PRESET_OFS: begin
        next_rdata[WIDTH-1:0] = sw_preset;
      end
      `PBC_STATUS_OFS: begin
        next_rdata[`PBC_STAT_COUNT_MSB:`PBC_STAT_COUNT_LSB] = count_value_o;
        next_rdata[`PBC_STAT_TERM_BIT]                       = terminal_flag_o;
        next_rdata[`PBC_STAT_ACT_MSB:`PBC_STAT_ACT_LSB]     = last_action;
        next_rdata[`PBC_STAT_ASYNC_BIT]                      = (ASYNC_CLEAR != 0);
      end
      `PBC_WRAPS_OFS: begin
        next_rdata[WRAP_WIDTH-1:0] = wraps;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // zero wait states, always okay
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (take_read) begin
        hrdata_o <= next_rdata;
      end
    end
  end

endmodule

// ### rtl/presettable_binary_counter4_regs.vh
// register map, field positions, reset values and action codes of the
// presettable binary counter; included by the counter files by bare name
`ifndef PRESETTABLE_BINARY_COUNTER4_REGS_VH
`define PRESETTABLE_BINARY_COUNTER4_REGS_VH

// byte addresses of the word registers
`define PBC_CTRL_OFS        8'h00
`define PBC_PRESET_OFS      8'h04
`define PBC_STATUS_OFS      8'h08
`define PBC_WRAPS_OFS       8'h0c
`define PBC_CMD_OFS         8'h10

// control register fields
`define PBC_CTRL_GATE_BIT   0
`define PBC_CTRL_RST        1'h1

// command register fields (write only, read as zero)
`define PBC_CMD_LOAD_BIT    0
`define PBC_CMD_CLEAR_BIT   1

// status register fields
`define PBC_STAT_COUNT_LSB  0
`define PBC_STAT_COUNT_MSB  3
`define PBC_STAT_TERM_BIT   4
`define PBC_STAT_ACT_LSB    8
`define PBC_STAT_ACT_MSB    9
`define PBC_STAT_ASYNC_BIT  16

// reset values
`define PBC_PRESET_RST      4'h0
`define PBC_WRAPS_RST       16'h0000

// action taken at the last clock edge
`define PBC_ACT_HOLD        2'h0
`define PBC_ACT_COUNT       2'h1
`define PBC_ACT_LOAD        2'h2
`define PBC_ACT_CLEAR       2'h3

// ahb-lite transfer type bit that marks an active transfer
`define PBC_HTRANS_ACTIVE   1

`endif

// ### rtl/count_stage4.v
// four-stage presettable up-counter with clear, load, count and hold
// assumes all controls are synchronous to sys_clk_i; the asynchronous
// clear is used only when ASYNC_CLEAR is set
`include "presettable_binary_counter4_regs.vh"

module count_stage4 #(
  parameter WIDTH       = 4,
  parameter ASYNC_CLEAR = 1
) (
  input  wire             sys_clk_i,
  input  wire             async_clear_n_i,
  input  wire             sync_clear_i,
  input  wire             load_i,
  input  wire             enable_parallel_i,
  input  wire             enable_trickle_i,
  input  wire [WIDTH-1:0] preset_value_i,
  output reg  [WIDTH-1:0] count_value_o,
  output reg  [1:0]       last_action_o,
  output wire             wrap_o
);

  reg [WIDTH-1:0] next_count;
  reg [1:0]       next_action;
  wire            count_en;
  wire            at_top;

  assign count_en = enable_parallel_i & enable_trickle_i;
  assign at_top   = &count_value_o;
  assign wrap_o   = ~sync_clear_i & ~load_i & count_en & at_top;

  // fixed precedence: clear, load, count, hold
  always @* begin
    next_count  = count_value_o;
    next_action = `PBC_ACT_HOLD;
    if (sync_clear_i) begin
      next_count  = {WIDTH{1'b0}};
      next_action = `PBC_ACT_CLEAR;
    end else if (load_i) begin
      next_count  = preset_value_i;
      next_action = `PBC_ACT_LOAD;
    end else if (count_en) begin
      next_count  = count_value_o + {{(WIDTH-1){1'b0}}, 1'b1};
      next_action = `PBC_ACT_COUNT;
    end
  end

  // all stages change together on the rising edge, or at once on the asynchronous clear when ASYNC_CLEAR is set
  generate
    if (ASYNC_CLEAR != 0) begin : g_async
      always @(posedge sys_clk_i or negedge async_clear_n_i) begin
        if (!async_clear_n_i) begin
          count_value_o <= {WIDTH{1'b0}};
          last_action_o <= `PBC_ACT_CLEAR;
        end else begin
          count_value_o <= next_count;
          last_action_o <= next_action;
        end
      end
    end else begin : g_sync
      always @(posedge sys_clk_i) begin
        count_value_o <= next_count;
        last_action_o <= next_action;
      end
    end
  endgenerate

endmodule

// ### testbench/pbc_checker.sv
// assertions on the counter pins and bus response of the binary counter
// assumes no software load or clear; either clear variant
module pbc_checker #(
  parameter WIDTH       = 4,
  parameter ASYNC_CLEAR = 1
) (
  input logic             sys_clk_i,
  input logic             rst_i,
  input logic             async_clear_n_i,
  input logic             sync_clear_n_i,
  input logic             load_n_i,
  input logic             enable_parallel_i,
  input logic             enable_trickle_i,
  input logic [WIDTH-1:0] preset_value_i,
  input logic [WIDTH-1:0] count_value_o,
  input logic             terminal_flag_o,
  input logic             hreadyout_o,
  input logic             hresp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic aclr;
  logic sclr;
  logic run;
  logic up;
  logic idle;
  // only the clear pin of the built variant acts
  assign aclr = (ASYNC_CLEAR != 0) && !async_clear_n_i;
  assign sclr = (ASYNC_CLEAR == 0) && !sync_clear_n_i;
  assign run = load_n_i && !aclr && !sclr;
  assign up = run && enable_parallel_i && enable_trickle_i;
  assign idle = run && !(enable_parallel_i && enable_trickle_i);
  count_up_a: assert property (up |=> aclr ||
    count_value_o == $past(count_value_o) + 1'b1) else $error("count did not advance");
  wrap_zero_a: assert property (up && (&count_value_o) |=>
    aclr || count_value_o == '0) else $error("no wrap to zero");
  load_copy_a: assert property (!load_n_i && !aclr && !sclr |=>
    aclr || count_value_o == $past(preset_value_i)) else $error("load lost");
  hold_still_a: assert property (idle |=> aclr ||
    $stable(count_value_o)) else $error("count moved while held");
  term_flag_a: assert property (terminal_flag_o ==
    (enable_trickle_i && (&count_value_o))) else $error("terminal flag wrong");
  async_zero_a: assert property (aclr |->
    count_value_o == '0) else $error("clear did not zero count");
  sync_zero_a: assert property (sclr |=>
    count_value_o == '0) else $error("sync clear did not zero count");
  reset_zero_a: assert property ($fell(rst_i) |-> count_value_o == '0 ##1
    count_value_o == '0 || !$past(run) || $past(up)) else $error("count not zero after reset");
  bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or error");
  wrap_c: cover property (up && (&count_value_o));
  load_c: cover property (!load_n_i && !aclr && !sclr);
  clear_c: cover property ($fell(async_clear_n_i) && ASYNC_CLEAR != 0);
  sync_c: cover property (sclr && !load_n_i);
endmodule

bind presettable_binary_counter4 pbc_checker #(.WIDTH(WIDTH), .ASYNC_CLEAR(ASYNC_CLEAR))
  chk_u (.sys_clk_i, .rst_i, .async_clear_n_i, .sync_clear_n_i, .load_n_i,
  .enable_parallel_i, .enable_trickle_i, .preset_value_i, .count_value_o, .terminal_flag_o,
  .hreadyout_o, .hresp_o);

// ### testbench/cascade_stage_model.sv
// behavioural upper cascade stage fed by the counter's terminal flag
// assumes the counter's clock and its synchronous active-high reset
module cascade_stage_model (
  input  logic       sys_clk_i,
  input  logic       rst_i,
  input  logic       carry_i,
  input  logic       enable_i,
  output logic [3:0] upper_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // flag used as a count enable, never as a clock
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      upper_o <= 4'h0;
    else if (carry_i && enable_i)
      upper_o <= upper_o + 4'h1;
  end
endmodule

// ### testbench/testbench.sv
// self-checking bench of the binary counter, its cascade and register slave
// builds both clear variants, dut_u asynchronous and sync_u synchronous; pins and bus move at rising edges
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        async_clear_n_i = 1'b1;
  logic        sync_clear_n_i = 1'b1;
  logic        load_n_i = 1'b1;
  logic        enable_parallel_i = 1'b0;
  logic        enable_trickle_i = 1'b0;
  logic [3:0]  preset_value_i = 4'h0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  wire  [3:0]  count_value_o;
  wire  [3:0]  upper;
  wire  [31:0] hrdata_o;
  wire         terminal_flag_o;
  wire         hreadyout_o;
  wire         hresp_o;
  wire  [3:0]  sync_count;
  wire  [31:0] sync_rdata;
  wire         sync_ready;
  int          num_errors = 0;
  int          comparisons = 0;
  presettable_binary_counter4 dut_u (.sys_clk_i, .rst_i, .async_clear_n_i, .sync_clear_n_i,
    .load_n_i, .enable_parallel_i, .enable_trickle_i, .preset_value_i, .count_value_o,
    .terminal_flag_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o);
  // synchronous clear variant on the same pins and bus
  presettable_binary_counter4 #(.ASYNC_CLEAR(0)) sync_u (.sys_clk_i, .rst_i, .async_clear_n_i,
    .sync_clear_n_i, .load_n_i, .enable_parallel_i, .enable_trickle_i, .preset_value_i,
    .count_value_o(sync_count), .terminal_flag_o(), .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i(sync_ready), .hrdata_o(sync_rdata),
    .hreadyout_o(sync_ready), .hresp_o());
  cascade_stage_model model_u (.sys_clk_i, .rst_i, .carry_i(terminal_flag_o),
    .enable_i(enable_parallel_i), .upper_o(upper));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic drv(input logic c, l, p, t, input logic [3:0] v);
    @(posedge sys_clk_i);
    {async_clear_n_i, load_n_i, enable_parallel_i, enable_trickle_i, preset_value_i} <=
      {c, l, p, t, v};
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    if (hreadyout_o !== 1'b1) begin
      num_errors++;
      conclude;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    @(posedge sys_clk_i);
    {hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'b1, 2'h2, a, w};
    wait_ready;
    {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, wd};
    wait_ready;
    rd = hrdata_o;
  endtask
  task automatic t_count;
    drv(1, 0, 1, 1, 4'he);
    drv(1, 1, 1, 1, 4'he);
    #1 check("count", count_value_o, 4'he);
    drv(1, 1, 1, 0, 4'h0);
    #1 check("count", count_value_o, 4'hf);
    check("flag", terminal_flag_o, 0);
    drv(1, 1, 1, 0, 4'h0);
    #1 check("count", count_value_o, 4'hf);
    drv(1, 1, 0, 1, 4'h0);
    #1 check("flag", terminal_flag_o, 1);
    drv(1, 1, 1, 1, 4'h0);
    #1 check("upper", upper, 0);
    drv(1, 1, 0, 0, 4'h0);
    #1 check("count", count_value_o, 0);
    check("upper", upper, 1);
  endtask
  task automatic t_prio;
    drv(1, 0, 1, 1, 4'h3);
    drv(1, 1, 0, 0, 4'h3);
    #1 check("count", count_value_o, 4'h3);
    drv(0, 0, 1, 1, 4'h9);
    #1 check("count", count_value_o, 0);
    drv(0, 0, 1, 1, 4'h9);
    #1 check("count", count_value_o, 0);
    check("sync count", sync_count, 4'h9);
    drv(1, 1, 0, 0, 4'h9);
    drv(1, 1, 0, 0, 4'h9);
    #1 check("count", count_value_o, 0);
  endtask
  task automatic t_bus;
    logic [31:0] r;
    bus(0, 32'h0, 32'h0, r);
    check("ctrl", r, 32'h1);
    bus(1, 32'h4, 32'ha, r);
    bus(0, 32'h4, 32'h0, r);
    check("preset", r, 32'ha);
    bus(0, 32'h20, 32'h0, r);
    check("unmapped", r, 32'h0);
    bus(0, 32'h8, 32'h0, r);
    check("status", r, 32'h10000);
    check("sync status", sync_rdata, 32'h9);
    bus(0, 32'hc, 32'h0, r);
    check("wraps", r, 32'h1);
    bus(1, 32'hc, 32'h0, r);
    bus(0, 32'hc, 32'h0, r);
    check("wraps", r, 32'h0);
  endtask
  task automatic t_sync;
    drv(1, 1, 1, 1, 4'h5);
    sync_clear_n_i <= 1'b0;
    #1 check("sync count", sync_count, 4'h9);
    drv(1, 0, 1, 1, 4'h5);
    #1 check("sync count", sync_count, 4'h0);
    check("count", count_value_o, 4'h1);
    drv(1, 0, 1, 1, 4'h5);
    sync_clear_n_i <= 1'b1;
    #1 check("sync count", sync_count, 4'h0);
    check("count", count_value_o, 4'h5);
    drv(1, 1, 0, 0, 4'h5);
    #1 check("sync count", sync_count, 4'h5);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 check("count", count_value_o, 0);
    t_count;
    t_prio;
    t_bus;
    t_sync;
    conclude;
  end
endmodule
